// File: acs_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// conversion sequencer top
// ****************************************************************
// Summary of operation
// - conversion clock is system clock divided by eight
// - filter runs exactly decimation-rate conversion clock periods
// - channel change waits sixteen conversion clocks first
// - decimation setting also fixes 7-12 bit resolution
// - host request converts selected channels in ascending order
// - results are two's complement
// - single-ended results never negative
// - differential signed, 2047 to -2048 at 12 bits
// - pins single-ended or paired differential
// - mux also offers temperature and supply third
module acs_top (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       nrst,
   // register port
   input  wire logic [acs_pkg::ADDR_W-1:0] addr,
   input  wire logic [acs_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output var  logic [acs_pkg::DATA_W-1:0] rdata,
   // modulator bitstream
   input  wire logic                       mod_bit,
   // analog front end steering
   output var  acs_pkg::acs_afe_t          afe,
   // status pins
   output var  logic                       busy,
   output var  logic                       done
);
   import acs_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   acs_bus_req_t        req;                                 // bundled bus request
   acs_state_t          state_r;                             // sequencer state
   acs_state_t          state_nxt;                           // next sequencer state
   logic                diff_r;                              // pin pair differential
   logic [2:0]          res_code_r;                          // resolution code
   logic [3:0]          chmask_r;                            // enabled channels
   logic [2:0]          idx_r;                               // next slot to search from
   acs_chan_t           ch_r;                                // channel being converted
   logic                last_vld_r;                          // a previous channel exists
   acs_chan_t           last_ch_r;                           // previous channel
   logic                last_diff_r;                         // previous differential mode
   logic [CNT_W-1:0]    tcnt_r;                              // tick counter
   logic                done_r;                              // results waiting
   logic [DATA_W-1:0]   res_r [NUM_CH];                      // held results
   logic [DATA_W-1:0]   rdata_r;                             // read data register

   logic                tick;                                // conversion clock tick
   logic [CNT_W-1:0]    ones;                                // decimation count
   logic                wr_ctrl;                             // control write
   logic                rd_stat;                             // status read
   logic                start;                               // accepted request
   logic [3:0]          eff_mask;                            // mask after pairing
   logic                found;                               // a channel remains
   acs_chan_t           next_ch;                             // next channel found
   logic                chan_changed;                        // selection differs
   logic [2:0]          res_code;                            // clamped resolution code
   logic [CNT_W-1:0]    rate;                                // decimation rate
   logic                settle_end;                          // settling finished
   logic                filt_end;                            // filter window finished
   logic                store;                               // result capture cycle
   logic                seq_end;                             // sequence finished
   logic signed [14:0]  diff_val;                            // two ones minus rate
   logic signed [14:0]  half_val;                            // scaled to resolution
   logic signed [14:0]  top_val;                             // largest positive code
   logic signed [14:0]  sat_val;                             // saturated value
   logic signed [14:0]  fin_val;                             // after single-ended clamp
   logic [DATA_W-1:0]   rd_mux;                              // read selection

   // ****************************************************************
   // sub blocks
   // ****************************************************************

   // conversion clock tick
   acs_clkdiv u_div (
      .mclk (mclk),
      .nrst (nrst),
      .tick (tick)
   );

   // decimation counter, cleared while a channel is picked
   acs_decim u_dec (
      .mclk    (mclk),
      .nrst    (nrst),
      .clr     (state_r == ST_PICK),
      .en      ((state_r == ST_FILT) && tick),
      .mod_bit (mod_bit),
      .ones    (ones)
   );

   // ****************************************************************
   // register decode
   // ****************************************************************
   assign req     = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wr_ctrl = req.wr && (req.addr == OFF_CTRL);
   assign rd_stat = req.rd && (req.addr == OFF_STATUS);

   // request refused while running or while results still unread
   assign start   = wr_ctrl && req.wdata[CTRL_START] && (state_r == ST_IDLE)
                    && !done_r;

   // ****************************************************************
   // channel search
   // ****************************************************************

   // in pair mode slot zero converts both pins, slot one is skipped
   assign eff_mask = diff_r ? (chmask_r & 4'hD) : chmask_r;

   // lowest enabled slot at or above the search index
   always_comb begin
      found   = 1'b0;
      next_ch = CH_PIN0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (eff_mask[i] && (3'(i) >= idx_r)) begin
            found   = 1'b1;
            next_ch = acs_chan_t'(2'(i));
         end
      end
   end

   // settling needed when mux setting differs from the last one
   assign chan_changed = !last_vld_r || (next_ch != last_ch_r)
                         || (diff_r != last_diff_r);

   // ****************************************************************
   // timing
   // ****************************************************************
   assign res_code   = (res_code_r > RES_CODE_MAX) ? RES_CODE_MAX : res_code_r;
   // rate is two to the resolution, 128 up to 4096 ticks;
   // four bit shift amount so code plus seven never wraps
   assign rate       = CNT_W'(1) << (4'(res_code) + 4'(RES_MIN));
   assign settle_end = tick && (tcnt_r[4:0] == SETTLE_LAST);
   assign filt_end   = tick && (tcnt_r == rate - 13'h0001);
   assign store      = (state_r == ST_STORE);
   assign seq_end    = (state_r == ST_PICK) && !found;

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            // wait for an accepted host request
            if (start) begin
               state_nxt = ST_PICK;
            end
         end
         ST_PICK: begin
            if (!found) begin
               // no enabled slot left: sequence over
               state_nxt = ST_IDLE;
            end else if (chan_changed) begin
               // new mux setting needs its settling time
               state_nxt = ST_SETTLE;
            end else begin
               // same setting as last time: filter at once
               state_nxt = ST_FILT;
            end
         end
         ST_SETTLE: begin
            // sixteen ticks before the filter starts
            if (settle_end) begin
               state_nxt = ST_FILT;
            end
         end
         ST_FILT: begin
            // window closes on its last rate tick
            if (filt_end) begin
               state_nxt = ST_STORE;
            end
         end
         ST_STORE: begin
            // one cycle to latch the result
            state_nxt = ST_PICK;
         end
         default: begin
            // unused state codes return to idle
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // tick counter, restarts on every state change
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tcnt_r <= '0;
      end else if (state_nxt != state_r) begin
         // every new state counts from zero
         tcnt_r <= '0;
      end else if (tick) begin
         tcnt_r <= tcnt_r + 13'h0001;
      end
   end

   // search index and current channel
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         idx_r <= '0;
         ch_r  <= CH_PIN0;
      end else if (start) begin
         // a new sequence searches from slot zero
         idx_r <= '0;
      end else if ((state_r == ST_PICK) && found) begin
         // later searches start one slot higher
         ch_r  <= next_ch;
         idx_r <= {1'b0, next_ch} + 3'h1;
      end
   end

   // remembers the last converted selection
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         last_vld_r  <= 1'b0;
         last_ch_r   <= CH_PIN0;
         last_diff_r <= 1'b0;
      end else if (store) begin
         last_vld_r  <= 1'b1;
         last_ch_r   <= ch_r;
         last_diff_r <= diff_r;
      end
   end

   // ****************************************************************
   // configuration
   // ****************************************************************

   // writes to control are ignored while a sequence runs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         diff_r     <= 1'b0;
         res_code_r <= RES_RST;
         chmask_r   <= CHMASK_RST;
      end else if (wr_ctrl && (state_r == ST_IDLE)) begin
         // settings written with start apply at once
         diff_r     <= req.wdata[CTRL_DIFF];
         res_code_r <= req.wdata[CTRL_RES_LSB +: 3];
         chmask_r   <= req.wdata[CTRL_CH_LSB +: NUM_CH];
      end
   end

   // ****************************************************************
   // result formatting
   // ****************************************************************

   // ones span 0..rate, so two ones minus rate spans -rate..rate
   assign diff_val = 15'(signed'({2'b00, ones}) <<< 1) - signed'({2'b00, rate});
   assign half_val = diff_val >>> 1;
   assign top_val  = signed'({2'b00, (rate >> 1)}) - 15'sd1;
   assign sat_val  = (half_val > top_val) ? top_val : half_val;

   // single-ended channels clamp at zero, the pair keeps its sign
   assign fin_val  = (!(diff_r && (ch_r == CH_PIN0)) && sat_val[14])
                     ? 15'sd0 : sat_val;

   // one held result per channel, written only by its own store
   for (genvar g = 0; g < NUM_CH; g++) begin : g_res
      always_ff @(posedge mclk or negedge nrst) begin
         if (!nrst) begin
            res_r[g] <= '0;
         end else if (store && (ch_r == acs_chan_t'(2'(g)))) begin
            res_r[g] <= {fin_val[14], fin_val};
         end
      end
   end

   // ****************************************************************
   // completion and read back
   // ****************************************************************

   // done sets at sequence end and wins over a clearing status read
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 1'b0;
      end else if (seq_end) begin
         done_r <= 1'b1;
      end else if (rd_stat) begin
         done_r <= 1'b0;
      end
   end

   // read selection, unmapped addresses read zero
   always_comb begin
      rd_mux = '0;
      case (req.addr)
         OFF_CTRL: begin
            // start bit is a pulse and reads zero
            rd_mux[CTRL_DIFF]            = diff_r;
            rd_mux[CTRL_RES_LSB +: 3]    = res_code_r;
            rd_mux[CTRL_CH_LSB +: NUM_CH] = chmask_r;
         end
         OFF_STATUS: begin
            // running and results-waiting flags
            rd_mux[STAT_BUSY] = (state_r != ST_IDLE);
            rd_mux[STAT_DONE] = done_r;
         end
         default: begin
            // one held result per channel slot
            if ((req.addr >= OFF_RES0) && (req.addr <= OFF_RES3)) begin
               rd_mux = res_r[2'(req.addr - OFF_RES0)];
            end
         end
      endcase
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= '0;
      end else if (req.rd) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= '0;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign rdata    = rdata_r;
   // busy covers every state but idle
   assign busy     = (state_r != ST_IDLE);
   assign done     = done_r;
   // steering built as one struct, a single driver for the port
   assign afe      = '{sel:  ch_r,
                       diff: diff_r && (ch_r == CH_PIN0),
                       run:  (state_r == ST_SETTLE) || (state_r == ST_FILT)};

endmodule : acs_top
`default_nettype wire

// File: acs_pkg.sv
// ****************************************************************
// shared constants and types of the conversion sequencer
// ****************************************************************
package acs_pkg;

   // clocking: system clock divided down to the conversion clock
   localparam int unsigned SYS_CLK_HZ   = 32_000_000;                 // system clock
   localparam int unsigned CONV_CLK_HZ  = 4_000_000;                  // conversion clock
   localparam int unsigned CONV_DIV     = SYS_CLK_HZ / CONV_CLK_HZ;   // divide ratio
   localparam int unsigned DIV_W        = 3;                          // divider counter width
   localparam logic [2:0]  DIV_LAST     = 3'(CONV_DIV - 1);           // last divider count

   // settling and filter lengths, in conversion clock periods
   localparam int unsigned SETTLE_TICKS = 16;                         // settling wait
   localparam logic [4:0]  SETTLE_LAST  = 5'(SETTLE_TICKS - 1);       // last settle count
   localparam int unsigned CNT_W        = 13;                         // holds up to 4096
   localparam int unsigned RES_MIN      = 7;                          // coarsest resolution
   localparam logic [2:0]  RES_CODE_MAX = 3'h5;                       // code for 12 bits

   // register port
   localparam int unsigned ADDR_W       = 4;                          // address width
   localparam int unsigned DATA_W       = 16;                         // data width
   localparam logic [3:0]  OFF_CTRL     = 4'h0;                       // control
   localparam logic [3:0]  OFF_STATUS   = 4'h1;                       // status
   localparam logic [3:0]  OFF_RES0     = 4'h4;                       // first result
   localparam logic [3:0]  OFF_RES3     = 4'h7;                       // last result

   // control field positions
   localparam int unsigned CTRL_START   = 0;                          // start a sequence
   localparam int unsigned CTRL_DIFF    = 1;                          // pin pair differential
   localparam int unsigned CTRL_RES_LSB = 4;                          // resolution code
   localparam int unsigned CTRL_CH_LSB  = 8;                          // channel enable mask
   localparam logic [2:0]  RES_RST      = 3'h0;                       // 7 bits after reset
   localparam logic [3:0]  CHMASK_RST   = 4'h1;                       // pin zero after reset

   // status field positions
   localparam int unsigned STAT_BUSY    = 0;                          // sequence running
   localparam int unsigned STAT_DONE    = 1;                          // results waiting

   // input multiplexer channels, in conversion order
   localparam int unsigned NUM_CH       = 4;                          // channel count
   typedef enum logic [1:0] {
      CH_PIN0    = 2'b00,                                            // analog_pin_zero
      CH_PIN1    = 2'b01,                                            // analog_pin_one
      CH_TEMP    = 2'b10,                                            // temperature sensor
      CH_SUPPLY3 = 2'b11                                             // analog_core_supply / 3
   } acs_chan_t;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,                                            // waiting for request
      ST_PICK   = 3'b001,                                            // find next channel
      ST_SETTLE = 3'b010,                                            // let the mux settle
      ST_FILT   = 3'b011,                                            // decimation running
      ST_STORE  = 3'b100                                             // capture result
   } acs_state_t;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;                                       // register address
      logic [DATA_W-1:0] wdata;                                      // write data
      logic              wr;                                         // write strobe
      logic              rd;                                         // read strobe
   } acs_bus_req_t;

   // analog front end steering
   typedef struct packed {
      acs_chan_t sel;                                                // multiplexer select
      logic      diff;                                               // differential pair
      logic      run;                                                // modulator running
   } acs_afe_t;

endpackage : acs_pkg

// File: acs_clkdiv.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// conversion clock tick generator
// ****************************************************************
module acs_clkdiv (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // one-cycle tick per conversion clock period
   output var  logic tick
);
   import acs_pkg::*;

   logic [DIV_W-1:0] cnt_r;                                  // divider count
   logic [DIV_W-1:0] cnt_nxt;                                // next count
   logic             wrap;                                   // last count reached

   assign wrap    = (cnt_r == DIV_LAST);
   assign cnt_nxt = wrap ? '0 : cnt_r + 3'h1;

   // free running divide-by-eight
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= wrap;
      end
   end

endmodule : acs_clkdiv
`default_nettype wire

// File: acs_decim.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// modulator bit synchroniser and decimation counter
// ****************************************************************
module acs_decim (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     nrst,
   // control
   input  wire logic                     clr,
   input  wire logic                     en,
   // modulator bit from the analog side
   input  wire logic                     mod_bit,
   // count of ones over the filter window
   output var  logic [acs_pkg::CNT_W-1:0] ones
);
   import acs_pkg::*;

   logic       s1_r;                                         // first sync stage
   logic       s2_r;                                         // second sync stage
   logic       s3_r;                                         // third sync stage
   logic       bit_r;                                        // accepted modulator level
   logic       agree;                                        // stages two and three match

   assign agree = (s2_r == s3_r);

   // three stage synchroniser, level accepted once stages agree
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         bit_r <= 1'b0;
      end else begin
         s1_r  <= mod_bit;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         if (agree) begin
            bit_r <= s3_r;
         end
      end
   end

   // counts ones, one sample per conversion clock period
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ones <= '0;
      end else if (clr) begin
         ones <= '0;
      end else if (en && bit_r) begin
         ones <= ones + 13'h0001;
      end
   end

endmodule : acs_decim
`default_nettype wire

// File: acs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// *****
// port checker of the conversion sequencer
// *****
module acs_monitor (
   // clock and reset
   input wire logic                       mclk,
   input wire logic                       nrst,
   // register port
   input wire logic [acs_pkg::ADDR_W-1:0] addr,
   input wire logic [acs_pkg::DATA_W-1:0] wdata,
   input wire logic                       wr,
   input wire logic                       rd,
   input wire logic [acs_pkg::DATA_W-1:0] rdata,
   // analog side and status
   input wire logic                       mod_bit,
   input wire acs_pkg::acs_afe_t          afe,
   input wire logic                       busy,
   input wire logic                       done
);
   import acs_pkg::*;
   logic [15:0] run_cnt_r;   // cycles the front end has run so far
   // length of each settle plus filter stretch
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         run_cnt_r <= 16'h0000;
      end else begin
         run_cnt_r <= afe.run ? run_cnt_r + 16'h0001 : 16'h0000;
      end
   end
   a_rdata_quiet: assert property (@(posedge mclk) disable iff (!nrst)
      !$past(rd) |-> rdata == 16'h0000) else $error("read data outside answer");
   a_run_busy: assert property (@(posedge mclk) disable iff (!nrst)
      afe.run |-> busy) else $error("front end runs while idle");
   a_start_taken: assert property (@(posedge mclk) disable iff (!nrst)
      wr && addr == OFF_CTRL && wdata[CTRL_START] && !busy && !done |=> busy)
      else $error("start not taken");
   a_done_holds: assert property (@(posedge mclk) disable iff (!nrst)
      done && !(rd && addr == OFF_STATUS) |=> done) else $error("done lost");
   a_done_idle: assert property (@(posedge mclk) disable iff (!nrst)
      done |-> !busy && !afe.run) else $error("busy while results wait");
   a_end_done: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(busy) |-> done) else $error("sequence ended without done");
   a_pair_slot: assert property (@(posedge mclk) disable iff (!nrst)
      afe.run && afe.diff |-> afe.sel == CH_PIN0) else $error("pair on wrong slot");
   a_run_length: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(afe.run) |-> run_cnt_r inside {[1000:33000]}) else $error("bad run length");
endmodule : acs_monitor
bind acs_top acs_monitor mon_u (.mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
   .mod_bit, .afe, .busy, .done);
`default_nettype wire

// File: acs_afe_model.sv
`timescale 1ns/100ps
`default_nettype none
// *****
// front end stand-in: each channel at plus or minus full scale
// *****
module acs_afe_model (
   // clock and steering
   input  wire logic              mclk,
   input  wire acs_pkg::acs_afe_t afe,
   // channels held at plus full scale
   input  wire logic [3:0]        hi_mask,
   // modulator bitstream
   output var  logic              mod_bit
);
   import acs_pkg::*;
   logic idle_r = 1'b0;   // toggles while stopped so a stale level never counts
   always @(posedge mclk) begin
      idle_r <= ~idle_r;
   end
   // pins, temperature and supply third each give their own level
   assign mod_bit = afe.run ? hi_mask[afe.sel] : idle_r;
endmodule : acs_afe_model
`default_nettype wire

// File: acs_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
// *****
// self-checking bench of the conversion sequencer
// *****
module acs_top_bench;
   import acs_pkg::*;
   logic              mclk, nrst, wr, rd, mod_bit, busy, done;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   acs_afe_t          afe;
   logic [3:0]        hi_mask;   // channels at plus full scale
   int                err_total, checks;
   acs_top dut_u (.mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .mod_bit, .afe, .busy, .done);
   acs_afe_model afe_u (.mclk, .afe, .hi_mask, .mod_bit);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp, input string what);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask : bus_rd
   // start, wait for done under a bound, time it, try a refused restart
   task automatic run_seq(input logic [15:0] ctrl, input logic [3:0] hi, input int tmin);
      int n;
      n = 0;
      hi_mask <= hi;
      bus_wr(OFF_CTRL, ctrl);
      while (done !== 1'b1 && n < 40000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 40000) begin
         $display("[ERR] done wait expected 1 seen 0");
         err_total++;
         end_sim();
      end
      if (tmin > 0) chk("conv time", 16'h1, 16'(n inside {[tmin-8:tmin+16]}));
      bus_wr(OFF_CTRL, ctrl);
      @(posedge mclk);
      #1;
      chk("restart busy", 16'h0, {15'h0, busy});
      bus_rd(OFF_STATUS, 16'h0002, "status");
   endtask : run_seq
   task automatic t_regs();
      bus_rd(OFF_CTRL, 16'h0100, "ctrl reset");
      bus_rd(4'hA, 16'h0000, "unmapped");
      bus_wr(OFF_CTRL, 16'h0F52);
      bus_rd(OFF_CTRL, 16'h0F52, "ctrl back");
      $display("test regs done");
   endtask : t_regs
   task automatic t_multi();
      run_seq(16'h0F01, 4'b1010, 0);
      for (int i = 0; i < 4; i++) begin
         bus_rd(4'(OFF_RES0 + i), i % 2 ? 16'h003F : 16'h0000, "channel");
      end
      bus_rd(OFF_STATUS, 16'h0000, "status clear");
      $display("test multi done");
   endtask : t_multi
   task automatic t_rates();
      for (int c = 0; c < 5; c++) begin
         run_seq(16'h0101 | 16'(c << 4), 4'b1, (c == 0 ? 144 : 1 << (7 + c)) * 8);
         bus_rd(OFF_RES0, 16'((1 << (6 + c)) - 1), "rate result");
      end
      $display("test rates done");
   endtask : t_rates
   task automatic t_diff();
      run_seq(16'h0F03, 4'b0000, 0);
      bus_rd(OFF_RES0, 16'hFFC0, "pair minus");
      bus_rd(OFF_RES3, 16'h0000, "supply low");
      run_seq(16'h0153, 4'b0001, 0);
      bus_rd(OFF_RES0, 16'h07FF, "pair plus 12");
      $display("test diff done");
   endtask : t_diff
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      hi_mask = 4'h0;
      err_total = 0;
      checks = 0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_multi();
      t_rates();
      t_diff();
      end_sim();
   end
endmodule : acs_top_bench
`default_nettype wire
